//--- design/sac_pkg.sv
// package for the main converter control block: register map, fields, reset values
// assumes a classic wishbone slave with 32-bit data and byte addresses
package sac_pkg;

	// ********************
	// register offsets
	// ********************
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_CONFIG  = 8'h04;
	localparam logic [7:0] OFF_RESULT  = 8'h08;
	localparam logic [7:0] OFF_WIN_LO  = 8'h0c;
	localparam logic [7:0] OFF_WIN_HI  = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_MASK    = 8'h18;
	localparam logic [7:0] OFF_BUSY    = 8'h1c;

	// ********************
	// field positions
	// ********************
	localparam int CTRL_START_BIT    = 0;
	localparam int CTRL_SHUTDOWN_BIT = 1;
	localparam int CTRL_LEFT_BIT     = 2;
	localparam int CTRL_INSIDE_BIT   = 3;
	localparam int CTRL_REF_BIT      = 4;
	localparam int CTRL_TRIG_LSB     = 8;
	localparam int CFG_CHAN_LSB      = 0;
	localparam int CFG_GAIN_LSB      = 4;
	localparam int CFG_DIFF_LSB      = 8;
	localparam int ST_DONE_BIT       = 0;
	localparam int ST_WIN_BIT        = 1;

	localparam int RES_W    = 12;
	localparam int CHAN_W   = 4;
	localparam int GAIN_W   = 3;
	localparam int PAIRS    = 4;
	localparam int NUM_CHAN = 9;

	// ********************
	// reset values
	// ********************
	localparam logic [31:0]       CTRL_RESET  = 32'h0000_0002;
	localparam logic [31:0]       CFG_RESET   = 32'h0000_0010;
	localparam logic [RES_W-1:0]  WIN_LO_RST  = 12'h000;
	localparam logic [RES_W-1:0]  WIN_HI_RST  = 12'hfff;
	localparam logic [1:0]        IRQ_RESET   = 2'h0;
	localparam logic [CHAN_W-1:0] TEMP_CHAN   = 4'h8;

	typedef enum logic [1:0] {
		TRIG_SOFT   = 2'h0,
		TRIG_TIMER2 = 2'h1,
		TRIG_TIMER3 = 2'h2,
		TRIG_EXT    = 2'h3
	} sac_trig_type;

	typedef enum logic [2:0] {
		GAIN_HALF = 3'h0,
		GAIN_1    = 3'h1,
		GAIN_2    = 3'h2,
		GAIN_4    = 3'h3,
		GAIN_8    = 3'h4,
		GAIN_16   = 3'h5
	} sac_gain_type;

	// analog front end settings, held steady for the analog core
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [PAIRS-1:0]  diff;
		logic [GAIN_W-1:0] gain;
		logic              ref_dac;
		logic              shutdown;
	} sac_afe_type;

endpackage : sac_pkg

//--- design/sac_conv_ctrl.sv
// control logic of the main converter: triggers, result latch, window compare, irq
// assumes the analog core answers a one-cycle start with a one-cycle done plus data
//
// Summary of operation
// - start from software, timer2, timer3 or external
// - completion sets done flag, interrupt if enabled
// - latch the result word on completion
// - software selects right or left justification
// - window compare raises interrupt inside or outside
// - repeat conversions, interrupt only on window hit
// - nine channels, one is temperature sensor
// - external pairs single-ended or differential
// - gain 0.5 to 16 in powers of two
// - shutdown stops all conversions
// - reference from pin or first dac output
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   timer2_ovf_i,
	input  wire logic                   timer3_ovf_i,
	input  wire logic                   ext_start_i,
	output logic                        conv_start_o,
	input  wire logic                   conv_done_i,
	input  wire logic [sac_pkg::RES_W-1:0] conv_data_i,
	output sac_pkg::sac_afe_type        afe_o,
	output logic                        irq_o
);

	// ********************
	// registers
	// ********************
	logic [31:0]                 ctrl;
	logic [31:0]                 cfg;
	logic [sac_pkg::RES_W-1:0]   win_lo;
	logic [sac_pkg::RES_W-1:0]   win_hi;
	logic [sac_pkg::RES_W-1:0]   result;
	logic [1:0]                  status;
	logic [1:0]                  mask;
	logic                        busy;
	logic                        ext_meta;
	logic                        ext_sync;
	logic                        ext_prev;
	logic                        soft_go;
	logic                        trig_hit;
	logic                        wr_hit;
	logic                        win_in;
	logic                        win_hit;
	logic [31:0]                 rdata;
	logic [31:0]                 next_ctrl;
	logic [31:0]                 next_cfg;
	logic [31:0]                 next_win_lo;
	logic [31:0]                 next_win_hi;
	logic [31:0]                 result_word;
	sac_pkg::sac_trig_type       trig_sel;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				v[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return v;
	endfunction : merge

	function automatic logic wr_at(input logic [7:0] a, input logic hit, input logic [7:0] off);
		return hit && (a == off);
	endfunction : wr_at

	// ********************
	// wishbone slave
	// ********************
	// one wait state: ack follows the request edge, dropped the cycle after
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			sac_pkg::OFF_CTRL:   rdata = {ctrl[31:1], 1'b0};
			sac_pkg::OFF_CONFIG: rdata = cfg;
			sac_pkg::OFF_RESULT: rdata = result_word;
			sac_pkg::OFF_WIN_LO: rdata = {20'h0, win_lo};
			sac_pkg::OFF_WIN_HI: rdata = {20'h0, win_hi};
			sac_pkg::OFF_STATUS: rdata = {30'h0, status};
			sac_pkg::OFF_MASK:   rdata = {30'h0, mask};
			sac_pkg::OFF_BUSY:   rdata = {31'h0, busy};
			default:             rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= rdata;
		end
	end

	// ********************
	// control and config
	// ********************
	assign next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i);
	assign next_cfg  = merge(cfg, wb_dat_i, wb_sel_i);
	// a function result cannot be sliced in place, so the merged word is held on a net first
	assign next_win_lo = merge({20'h0, win_lo}, wb_dat_i, wb_sel_i);
	assign next_win_hi = merge({20'h0, win_hi}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= sac_pkg::CTRL_RESET;
		end else if (wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_CTRL)) begin
			ctrl <= {16'h0, 6'h0, next_ctrl[sac_pkg::CTRL_TRIG_LSB +: 2], 3'h0, next_ctrl[4:1], 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= sac_pkg::CFG_RESET;
		end else if (wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_CONFIG)) begin
			cfg[3:0]   <= (next_cfg[3:0] < 4'(sac_pkg::NUM_CHAN)) ? next_cfg[3:0] : cfg[3:0];
			cfg[6:4]   <= (next_cfg[6:4] <= sac_pkg::GAIN_16) ? next_cfg[6:4] : cfg[6:4];
			cfg[11:8]  <= next_cfg[11:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_lo <= sac_pkg::WIN_LO_RST;
			win_hi <= sac_pkg::WIN_HI_RST;
		end else begin
			if (wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_WIN_LO)) begin
				win_lo <= next_win_lo[sac_pkg::RES_W-1:0];
			end
			if (wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_WIN_HI)) begin
				win_hi <= next_win_hi[sac_pkg::RES_W-1:0];
			end
		end
	end

	// analog settings go straight out of the registers
	assign afe_o.chan     = cfg[sac_pkg::CFG_CHAN_LSB +: sac_pkg::CHAN_W];
	assign afe_o.diff     = cfg[sac_pkg::CFG_DIFF_LSB +: sac_pkg::PAIRS];
	assign afe_o.gain     = cfg[sac_pkg::CFG_GAIN_LSB +: sac_pkg::GAIN_W];
	assign afe_o.ref_dac  = ctrl[sac_pkg::CTRL_REF_BIT];
	assign afe_o.shutdown = ctrl[sac_pkg::CTRL_SHUTDOWN_BIT];

	// ********************
	// trigger selection
	// ********************
	// external start is a pin: two flops, then an edge detect on the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= ext_start_i;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	assign soft_go  = wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_CTRL) && wb_sel_i[0] && wb_dat_i[sac_pkg::CTRL_START_BIT];
	assign trig_sel = sac_pkg::sac_trig_type'(ctrl[sac_pkg::CTRL_TRIG_LSB +: 2]);

	always_comb begin
		unique case (trig_sel)
			sac_pkg::TRIG_SOFT:   trig_hit = soft_go;
			sac_pkg::TRIG_TIMER2: trig_hit = timer2_ovf_i;
			sac_pkg::TRIG_TIMER3: trig_hit = timer3_ovf_i;
			sac_pkg::TRIG_EXT:    trig_hit = ext_sync && !ext_prev;
		endcase
	end

	// a trigger during a conversion or in shutdown is dropped, not queued
	assign conv_start_o = trig_hit && !busy && !ctrl[sac_pkg::CTRL_SHUTDOWN_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy <= 1'b0;
		end else if (conv_start_o) begin
			busy <= 1'b1;
		end else if (conv_done_i || ctrl[sac_pkg::CTRL_SHUTDOWN_BIT]) begin
			busy <= 1'b0;
		end
	end

	// ********************
	// result and window
	// ********************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result <= '0;
		end else if (conv_done_i && busy) begin
			result <= conv_data_i;
		end
	end

	// left justified puts the msb at bit 15 of the two result bytes
	assign result_word = ctrl[sac_pkg::CTRL_LEFT_BIT] ? {16'h0, result, 4'h0} : {20'h0, result};

	assign win_in  = (conv_data_i >= win_lo) && (conv_data_i <= win_hi);
	assign win_hit = conv_done_i && busy && (win_in == ctrl[sac_pkg::CTRL_INSIDE_BIT]);

	// ********************
	// interrupts
	// ********************
	// set beats a simultaneous write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= sac_pkg::IRQ_RESET;
		end else begin
			status[sac_pkg::ST_DONE_BIT] <= (conv_done_i && busy) ||
				(status[sac_pkg::ST_DONE_BIT] &&
				!(wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_STATUS) && wb_sel_i[0] && wb_dat_i[0]));
			status[sac_pkg::ST_WIN_BIT] <= win_hit ||
				(status[sac_pkg::ST_WIN_BIT] &&
				!(wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_STATUS) && wb_sel_i[0] && wb_dat_i[1]));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask <= sac_pkg::IRQ_RESET;
		end else if (wr_at(wb_adr_i, wr_hit, sac_pkg::OFF_MASK) && wb_sel_i[0]) begin
			mask <= wb_dat_i[1:0];
		end
	end

	// in background monitoring software leaves only the window bit unmasked
	assign irq_o = |(status & mask);

endmodule : sac_conv_ctrl

`default_nettype wire

//--- testbench/sac_conv_ctrl_assertions.sv
// port checker for the main converter control block
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_assertions (
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [7:0]                  wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	input wire logic                        timer2_ovf_i,
	input wire logic                        timer3_ovf_i,
	input wire logic                        ext_start_i,
	input wire logic                        conv_start_o,
	input wire logic                        conv_done_i,
	input wire logic [sac_pkg::RES_W-1:0]   conv_data_i,
	input wire sac_pkg::sac_afe_type        afe_o,
	input wire logic                        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wr = req & wb_we_i;
	wire logic go = wr & (wb_adr_i == 8'h00) & wb_sel_i[0] & wb_dat_i[0];
	property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_cause; conv_start_o |-> go | timer2_ovf_i | timer3_ovf_i | $past(ext_start_i, 2)
		| $past(ext_start_i, 3) | $past(ext_start_i, 4); endproperty
	a_cause: assert property (p_cause) else $error("start without trigger");
	property p_off; afe_o.shutdown & ~go |-> !conv_start_o; endproperty
	a_off: assert property (p_off) else $error("start in shutdown");
	property p_busy; conv_start_o |=> !conv_start_o; endproperty
	a_busy: assert property (p_busy) else $error("start while busy");
	property p_rise; $rose(irq_o) |-> $past(conv_done_i) | $past(wr); endproperty
	a_rise: assert property (p_rise) else $error("irq without cause");
	property p_fall; $fell(irq_o) |-> $past(wr) | $past(rst_i); endproperty
	a_fall: assert property (p_fall) else $error("flag lost");
	property p_afe; $changed(afe_o) |-> $past(wr) | $past(rst_i); endproperty
	a_afe: assert property (p_afe) else $error("afe moved");
	property p_chan; afe_o.chan <= sac_pkg::TEMP_CHAN; endproperty
	a_chan: assert property (p_chan) else $error("bad channel");
	property p_gain; afe_o.gain <= sac_pkg::GAIN_16; endproperty
	a_gain: assert property (p_gain) else $error("bad gain");
	property p_hole; req & !wb_we_i & (wb_adr_i == 8'h20) |=> wb_dat_o == 32'h0; endproperty
	a_hole: assert property (p_hole) else $error("unmapped read");
	c_start: cover property (conv_start_o);
	c_irq: cover property ($rose(irq_o));
	c_ext: cover property (conv_start_o & $past(ext_start_i, 3));
endmodule : sac_conv_ctrl_assertions
bind sac_conv_ctrl sac_conv_ctrl_assertions u_chk (.*);
`default_nettype wire

//--- testbench/sac_conv_ctrl_test.sv
// self-checking bench of the main converter control block
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_test;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic timer2_ovf_i = 1'b0, timer3_ovf_i = 1'b0, ext_start_i = 1'b0, conv_done_i = 1'b0;
	logic [7:0]           wb_adr_i = 8'h00;
	logic [3:0]           wb_sel_i = 4'hf;
	logic [31:0]          wb_dat_i = 32'h0, wb_dat_o, rd, ctrl;
	logic [11:0]          conv_data_i = 12'h000, d, cfg;
	logic                 wb_ack_o, conv_start_o, irq_o;
	sac_pkg::sac_afe_type afe_o;
	int                   miscompares = 0, n_compared = 0, n_start = 0, cycles = 0;
	logic [7:0]           ra [8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	logic [31:0]          rv [8] = '{32'h2, 32'h10, 32'h0, 32'hfff, 32'h0, 32'h0, 32'h0, 32'h0};
	always #5 clk_i = ~clk_i;
	sac_conv_ctrl dut (.*);
	always @(posedge clk_i) begin
		cycles++;
		if (conv_start_o === 1'b1)
			n_start++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [31:0] just(input logic [11:0] v, input logic l);
		return l ? {16'h0, v, 4'h0} : {20'h0, v};
	endfunction : just
	function automatic logic win(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi, input logic ins);
		return ((v >= lo) && (v <= hi)) == ins;
	endfunction : win
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= v;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// trigger, then retrigger both timers while busy: only one start may follow
	task automatic conv(input int t, input logic [11:0] v, input int n);
		int s;
		s = n_start;
		if (t == 0) wb(1'b1, 8'h00, ctrl | 32'h1);
		timer2_ovf_i <= (t == 1);
		timer3_ovf_i <= (t == 2);
		ext_start_i <= (t == 3);
		@(posedge clk_i);
		timer2_ovf_i <= 1'b0;
		timer3_ovf_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		ext_start_i <= 1'b0;
		timer2_ovf_i <= 1'b1;
		timer3_ovf_i <= 1'b1;
		@(posedge clk_i);
		timer2_ovf_i <= 1'b0;
		timer3_ovf_i <= 1'b0;
		@(posedge clk_i);
		chk("starts", s + n, n_start);
		conv_done_i <= 1'b1;
		conv_data_i <= v;
		@(posedge clk_i);
		conv_done_i <= 1'b0;
		conv_data_i <= ~v;
		@(posedge clk_i);
	endtask : conv
	initial begin
		d = 12'($urandom(32'ha979cdd6));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset", rv[i], rd);
		end
		cfg = 12'h010;
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 12'h458 : (i == 1) ? 12'h069 : 12'($urandom) & 12'hf7f;
			wb(1'b1, 8'h04, {20'h0, d});
			cfg = {d[11:8], 1'b0, (d[6:4] <= 3'h5) ? d[6:4] : cfg[6:4], (d[3:0] <= 4'h8) ? d[3:0] : cfg[3:0]};
			chk("afe", 32'({cfg[3:0], cfg[11:8], cfg[6:4], 2'b01}), 32'(afe_o));
		end
		ctrl = 32'h0102;
		wb(1'b1, 8'h00, ctrl);
		conv(1, 12'h0, 0);
		chk("shutdown", 32'h0, 32'(n_start));
		wb(1'b1, 8'h18, 32'h1);
		for (int t = 0; t < 8; t++) begin
			d = 12'($urandom);
			ctrl = {22'h0, 2'(t), 3'h0, t[0], 1'b0, t[2], 2'b00};
			wb(1'b1, 8'h00, ctrl);
			chk("ref", 32'(t[0]), 32'(afe_o.ref_dac));
			conv(t % 4, d, 1);
			chk("irq", 32'h1, 32'(irq_o));
			wb(1'b0, 8'h08, 32'h0);
			chk("result", just(d, t[2]), rd);
			wb(1'b0, 8'h14, 32'h0);
			chk("status", {30'h0, win(d, 12'h000, 12'hfff, 1'b0), 1'b1}, rd);
			wb(1'b1, 8'h14, 32'h3);
		end
		wb(1'b1, 8'h0c, 32'h400);
		wb(1'b1, 8'h10, 32'h800);
		wb(1'b1, 8'h18, 32'h2);
		for (int k = 0; k < 12; k++) begin
			d = (k < 4) ? 12'h3ff + 12'(k[1:0] == 1) + 12'h3ff * 12'(k[1]) + 12'(k == 3) : 12'($urandom);
			ctrl = {22'h0, 2'h1, 4'h0, k[0], 3'h0};
			wb(1'b1, 8'h00, ctrl);
			conv(1, d, 1);
			chk("window", 32'(win(d, 12'h400, 12'h800, k[0])), 32'(irq_o));
			wb(1'b1, 8'h14, 32'h3);
		end
		complete_run();
	end
endmodule : sac_conv_ctrl_test
`default_nettype wire
